// File: common/fvs_pkg.sv
// Package: register map, field layout, reset values and shared types of the fault status block
`default_nettype none

package fvs_pkg;

    // ========================================================================
    // Register indices and byte addresses (byte address = four times index)
    // ========================================================================
    localparam int unsigned ADDR_W            = 12;
    localparam logic [11:0] IDX_FAULT_STATUS  = 12'h042;
    localparam logic [11:0] IDX_VOLT_ID       = 12'h043;
    localparam logic [11:0] IDX_ENABLE        = 12'h060;
    localparam logic [11:0] IDX_START         = 12'h061;
    localparam logic [11:0] IDX_IRQ_STATUS    = 12'h062;
    localparam logic [11:0] IDX_IRQ_MASK      = 12'h063;
    localparam logic [11:0] ADDR_FAULT_STATUS = 12'(IDX_FAULT_STATUS << 2);
    localparam logic [11:0] ADDR_VOLT_ID      = 12'(IDX_VOLT_ID << 2);
    localparam logic [11:0] ADDR_ENABLE       = 12'(IDX_ENABLE << 2);
    localparam logic [11:0] ADDR_START        = 12'(IDX_START << 2);
    localparam logic [11:0] ADDR_IRQ_STATUS   = 12'(IDX_IRQ_STATUS << 2);
    localparam logic [11:0] ADDR_IRQ_MASK     = 12'(IDX_IRQ_MASK << 2);

    // ========================================================================
    // Field positions and widths
    // ========================================================================
    localparam int unsigned STATUS_W     = 8;
    localparam int unsigned BIT_TWELVE   = 0;
    localparam int unsigned BIT_RESERVED = 1;
    localparam int unsigned BIT_FAN1     = 2;
    localparam int unsigned BIT_DIODE1   = 6;
    localparam int unsigned BIT_DIODE2   = 7;
    localparam int unsigned VID_W        = 5;
    localparam int unsigned FAN_N        = 4;
    localparam int unsigned DIODE_N      = 2;

    // ========================================================================
    // Reset values and fixed codes
    // ========================================================================
    localparam logic [7:0] STATUS_RESET        = 8'h00;
    localparam logic [7:0] STATUS_VALID        = 8'hFD;
    localparam logic [7:0] ENABLE_RESET        = 8'h00;
    localparam logic       START_RESET         = 1'b0;
    localparam logic [7:0] IRQ_MASK_RESET      = 8'h00;
    localparam logic [7:0] DIODE_FAULT_READING = 8'h80;

    // Layout of the fault status register, also used for enable, event and mask
    typedef struct packed {
        logic diode2_fault_flag;
        logic diode1_fault_flag;
        logic fan4_slow_flag;
        logic fan3_slow_flag;
        logic fan2_slow_flag;
        logic fan1_slow_flag;
        logic reserved_bit;
        logic twelve_volt_limit_flag;
    } fvs_status_t;

endpackage : fvs_pkg

`default_nettype wire

// File: src/fvs_status.sv
// Design: second fault status register, voltage id register and APB slave
// ============================================================================
// ============================================================================
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none

module fvs_status (
    // Clock and reset
    input  wire logic                 core_clk_i,
    input  wire logic                 rst_b_i,
    // APB slave
    input  wire logic                 psel_i,
    input  wire logic                 penable_i,
    input  wire logic                 pwrite_i,
    input  wire logic [11:0]          paddr_i,
    input  wire logic [31:0]          pwdata_i,
    input  wire logic [3:0]           pstrb_i,
    output logic      [31:0]          prdata_o,
    output logic                      pready_o,
    output logic                      pslverr_o,
    // 12V measurement engine
    input  wire logic [7:0]           volt12_reading_i,
    input  wire logic [7:0]           volt12_low_limit_i,
    input  wire logic [7:0]           volt12_high_limit_i,
    input  wire logic                 volt12_update_i,
    // Fan tach engines
    input  wire logic [3:0][15:0]     fan_tach_reading_i,
    input  wire logic [3:0][15:0]     fan_tach_min_i,
    input  wire logic [3:0]           fan_update_i,
    // Remote diode engines
    input  wire logic [1:0]           diode_fault_i,
    input  wire logic [1:0][7:0]      diode_temp_i,
    input  wire logic [1:0]           diode_update_i,
    output logic      [1:0][7:0]      diode_temp_reading_o,
    output logic      [1:0]           diode_limit_clear_o,
    // Asynchronous voltage id pins
    input  wire logic [4:0]           volt_id_pins_i,
    // Summary and interrupt
    output logic                      second_status_summary_o,
    output logic                      irq_o
);

    // ========================================================================
    // Comparison helpers
    // ========================================================================
    // Low limit is inclusive, high limit exclusive
    function automatic logic out_of_range(input logic [7:0] val,
                                          input logic [7:0] lo,
                                          input logic [7:0] hi);
        out_of_range = (val <= lo) || (val > hi);
    endfunction

    // A slow or stalled fan gives a long tach period
    function automatic logic tach_slow(input logic [15:0] val, input logic [15:0] min);
        tach_slow = (val > min);
    endfunction

    // ========================================================================
    // State
    // ========================================================================
    fvs_pkg::fvs_status_t status_ff;
    fvs_pkg::fvs_status_t nxt_status;
    logic [7:0]           enable_ff;
    logic [7:0]           nxt_enable;
    logic                 start_ff;
    logic [7:0]           irq_status_ff;
    logic [7:0]           nxt_irq_status;
    logic [7:0]           irq_mask_ff;
    logic [7:0]           active_ff;
    logic [4:0]           vid_meta_ff;
    logic [4:0]           vid_sync_ff;
    logic [31:0]          prdata_ff;
    logic                 pready_ff;
    logic                 pslverr_ff;
    logic                 irq_ff;
    logic                 summary_ff;
    logic [1:0]           limit_clear_ff;
    logic [1:0][7:0]      diode_reading_ff;

    // ========================================================================
    // APB decode
    // ========================================================================
    wire setup_w      = psel_i & ~penable_i;
    wire done_w       = psel_i & penable_i & pready_ff;
    wire hit_status_w = (paddr_i == fvs_pkg::ADDR_FAULT_STATUS);
    wire hit_vid_w    = (paddr_i == fvs_pkg::ADDR_VOLT_ID);
    wire hit_enable_w = (paddr_i == fvs_pkg::ADDR_ENABLE);
    wire hit_start_w  = (paddr_i == fvs_pkg::ADDR_START);
    wire hit_irq_w    = (paddr_i == fvs_pkg::ADDR_IRQ_STATUS);
    wire hit_mask_w   = (paddr_i == fvs_pkg::ADDR_IRQ_MASK);
    wire mapped_w     = hit_status_w | hit_vid_w | hit_enable_w |
                        hit_start_w | hit_irq_w | hit_mask_w;
    wire wr_low_w     = done_w & pwrite_i & pstrb_i[0];

    // Only the software-owned registers have write strobes; status and id have none
    wire wr_enable_w  = wr_low_w & hit_enable_w;
    wire wr_start_w   = wr_low_w & hit_start_w;
    wire wr_irq_w     = wr_low_w & hit_irq_w;
    wire wr_mask_w    = wr_low_w & hit_mask_w;
    wire rd_status_w  = done_w & ~pwrite_i & hit_status_w;

    // Read mux; unmapped addresses read zero and flag an error
    wire [31:0] rd_data_w =
        hit_status_w ? {24'h000000, status_ff}              :
        hit_vid_w    ? {27'h0000000, vid_sync_ff}           :
        hit_enable_w ? {24'h000000, enable_ff}              :
        hit_start_w  ? {31'h00000000, start_ff}             :
        hit_irq_w    ? {24'h000000, irq_status_ff}          :
        hit_mask_w   ? {24'h000000, irq_mask_ff}            :
                       32'h00000000;

    // ========================================================================
    // Event conditions and update strobes
    // ========================================================================
    wire [7:0] cond_w;
    wire [7:0] upd_w;
    wire [7:0] active_w;
    wire [7:0] set_w;
    wire [7:0] en_fall_w;

    assign cond_w[fvs_pkg::BIT_TWELVE] =
        out_of_range(volt12_reading_i, volt12_low_limit_i, volt12_high_limit_i);
    assign cond_w[fvs_pkg::BIT_RESERVED] = 1'b0;
    for (genvar k = 0; k < fvs_pkg::FAN_N; k++) begin : g_fan
        assign cond_w[fvs_pkg::BIT_FAN1 + k] =
            tach_slow(fan_tach_reading_i[k], fan_tach_min_i[k]);
    end
    assign cond_w[fvs_pkg::BIT_DIODE1] = diode_fault_i[0];
    assign cond_w[fvs_pkg::BIT_DIODE2] = diode_fault_i[1];

    assign upd_w = {diode_update_i, fan_update_i, 1'b0, volt12_update_i};

    // Diode faults are judged live so a read cannot clear a standing fault
    assign active_w = {diode_fault_i, active_ff[5:0]};

    // A bit can only rise on an update, with start and its enable both set
    assign set_w = {8{start_ff}} & upd_w & enable_ff & cond_w & fvs_pkg::STATUS_VALID;

    // Enable bits that a write is about to take down
    assign nxt_enable = wr_enable_w ? (pwdata_i[7:0] & fvs_pkg::STATUS_VALID) : enable_ff;
    assign en_fall_w  = enable_ff & ~nxt_enable;

    // ========================================================================
    // Status next value: clears first, then sets, so a set in the same cycle wins
    // ========================================================================
    always_comb begin
        nxt_status = status_ff;
        for (int i = 0; i < fvs_pkg::STATUS_W; i++) begin
            if (rd_status_w && prdata_ff[i] && !active_w[i]) begin
                nxt_status[i] = 1'b0;
            end
            if (start_ff && upd_w[i] && !enable_ff[i]) begin
                nxt_status[i] = 1'b0;
            end
            if ((i >= fvs_pkg::BIT_DIODE1) && en_fall_w[i]) begin
                nxt_status[i] = 1'b0;
            end
            if (set_w[i]) begin
                nxt_status[i] = 1'b1;
            end
        end
        nxt_status[fvs_pkg::BIT_RESERVED] = 1'b0;
    end

    // Interrupt events are rising status bits; write-one clears, new events win
    assign nxt_irq_status =
        (irq_status_ff & ~(wr_irq_w ? pwdata_i[7:0] : 8'h00)) | (nxt_status & ~status_ff);

    // ========================================================================
    // Status, enables and start
    // ========================================================================
    // Held bits survive until a read while inactive, an update while started and disabled or a dropped diode enable removes them
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            status_ff <= fvs_pkg::STATUS_RESET;
            enable_ff <= fvs_pkg::ENABLE_RESET;
            start_ff  <= fvs_pkg::START_RESET;
        end else begin
            status_ff <= nxt_status;
            enable_ff <= nxt_enable;
            if (wr_start_w) begin
                start_ff <= pwdata_i[0];
            end
        end
    end

    // Last judged condition of each measured input, refreshed only while started
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            active_ff <= 8'h00;
        end else begin
            active_ff <= (start_ff ? (upd_w & cond_w) | (~upd_w & active_ff) : active_ff);
        end
    end

    // ========================================================================
    // Diode reading registers
    // ========================================================================
    // Frozen while stopped; a fault substitutes the out-of-range code
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            diode_reading_ff <= '0;
        end else begin
            for (int k = 0; k < fvs_pkg::DIODE_N; k++) begin
                if (start_ff && diode_update_i[k]) begin
                    diode_reading_ff[k] <= diode_fault_i[k] ? fvs_pkg::DIODE_FAULT_READING
                                                            : diode_temp_i[k];
                end
            end
        end
    end

    // ========================================================================
    // Voltage id synchroniser
    // ========================================================================
    // Data only, no reset; the first stage feeds nothing but the second
    always_ff @(posedge core_clk_i) begin
        vid_meta_ff <= volt_id_pins_i;
        vid_sync_ff <= vid_meta_ff;
    end

    // ========================================================================
    // Interrupt registers and registered outputs
    // ========================================================================
    // Interrupt level lags the status by one cycle to come straight from a flop
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            irq_status_ff  <= 8'h00;
            irq_mask_ff    <= fvs_pkg::IRQ_MASK_RESET;
            irq_ff         <= 1'b0;
            summary_ff     <= 1'b0;
            limit_clear_ff <= 2'b00;
        end else begin
            irq_status_ff  <= nxt_irq_status;
            irq_ff         <= |(irq_status_ff & irq_mask_ff);
            summary_ff     <= |nxt_status;
            limit_clear_ff <= en_fall_w[fvs_pkg::BIT_DIODE2:fvs_pkg::BIT_DIODE1];
            if (wr_mask_w) begin
                irq_mask_ff <= pwdata_i[7:0] & fvs_pkg::STATUS_VALID;
            end
        end
    end

    // ========================================================================
    // APB response
    // ========================================================================
    // Read data is taken at setup; the clear-on-read uses that snapshot so a
    // bit set after the snapshot is never cleared unseen
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            prdata_ff  <= 32'h00000000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= psel_i & penable_i & ~pready_ff;
            if (setup_w) begin
                prdata_ff  <= rd_data_w;
                pslverr_ff <= ~mapped_w;
            end
        end
    end

    assign prdata_o                = prdata_ff;
    assign pready_o                = pready_ff;
    assign pslverr_o               = pslverr_ff;
    assign irq_o                   = irq_ff;
    assign second_status_summary_o = summary_ff;
    assign diode_limit_clear_o     = limit_clear_ff;
    assign diode_temp_reading_o    = diode_reading_ff;

    // ========================================================================
    // Assertions
    // ========================================================================
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);

    twelve_set_a: assert property (
        start_ff && volt12_update_i && enable_ff[0] && cond_w[0] |=> status_ff[0] ##1 1'b1)
        else $error("12V violation did not set bit 0");

    fan1_set_a: assert property (
        start_ff && fan_update_i[0] && enable_ff[2] && (fan_tach_reading_i[0] > fan_tach_min_i[0])
        |=> status_ff.fan1_slow_flag)
        else $error("slow fan 1 did not set bit 2");

    diode_set_a: assert property (
        start_ff && diode_update_i[1] && enable_ff[7] && diode_fault_i[1]
        |=> status_ff.diode2_fault_flag && diode_temp_reading_o[1] == 8'h80)
        else $error("diode 2 fault did not set bit 7");

    write_ignored_a: assert property (
        wr_low_w && (hit_status_w || hit_vid_w) && !(|upd_w) |=> $stable(status_ff))
        else $error("write changed the status register");

    read_clear_a: assert property (
        rd_status_w && prdata_ff[0] && !active_w[0] && !set_w[0] |=> !status_ff[0])
        else $error("read did not clear an inactive bit");

    bit_hold_a: assert property (
        status_ff[3] && !rd_status_w && !fan_update_i[1] |=> status_ff[3])
        else $error("fan 2 bit dropped without cause");

    diode_keep_a: assert property (
        rd_status_w && status_ff.diode1_fault_flag && diode_fault_i[0] && enable_ff[6]
        |=> status_ff.diode1_fault_flag)
        else $error("read cleared a standing diode fault");

    diode_disable_a: assert property (
        en_fall_w[6] && !set_w[6] |=> !status_ff.diode1_fault_flag && diode_limit_clear_o[0]
                         ##1 !diode_limit_clear_o[0])
        else $error("diode 1 disable did not clear its bits");

    no_rise_a: assert property (
        !enable_ff[0] && !status_ff[0] |=> !status_ff[0])
        else $error("bit 0 rose while disabled");

    disabled_clear_a: assert property (
        start_ff && fan_update_i[3] && !enable_ff[5] |=> !status_ff.fan4_slow_flag)
        else $error("disabled fan 4 bit not cleared on update");

    frozen_read_a: assert property (
        !start_ff |=> $stable(diode_temp_reading_o))
        else $error("diode reading changed while stopped");

    vid_read_a: assert property (
        setup_w && hit_vid_w |=> prdata_o[31:5] == 27'h0000000 && prdata_o[4:0] == $past(vid_sync_ff))
        else $error("id register read is wrong");

    reserved_zero_a: assert property (
        !status_ff.reserved_bit)
        else $error("reserved status bit is set");

    summary_track_a: assert property (
        second_status_summary_o == (|status_ff))
        else $error("summary does not follow the status bits");

    stopped_quiet_a: assert property (
        !start_ff && (status_ff == 8'h00) && !wr_start_w |=> status_ff == 8'h00)
        else $error("status bit set while stopped");

    diode_force_a: assert property (
        start_ff && diode_update_i[0] && diode_fault_i[0] |=> diode_temp_reading_o[0] == 8'h80)
        else $error("diode 1 reading not forced on fault");

    diode2_disable_a: assert property (
        en_fall_w[7] && !set_w[7] |=> !status_ff.diode2_fault_flag && diode_limit_clear_o[1])
        else $error("diode 2 disable did not clear its bits");

    temp_pass_a: assert property (
        start_ff && diode_update_i[1] && !diode_fault_i[1]
        |=> diode_temp_reading_o[1] == $past(diode_temp_i[1]))
        else $error("diode 2 reading not loaded on update");

    twelve_clear_a: assert property (
        start_ff && volt12_update_i && !enable_ff[0] |=> !status_ff.twelve_volt_limit_flag)
        else $error("disabled 12V bit not cleared on update");

    stuck_diode_a: assert property (
        start_ff && diode_update_i[0] && enable_ff[6] && diode_fault_i[0]
        |=> status_ff.diode1_fault_flag)
        else $error("diode 1 fault did not set bit 6");

    read_clear_c:   cover property (rd_status_w && (status_ff != 8'h00) ##1 status_ff == 8'h00);
    diode_force_c:  cover property (start_ff && diode_update_i[0] && diode_fault_i[0]);
    irq_raise_c:    cover property (!irq_o ##1 irq_o);
    set_on_read_c:  cover property (rd_status_w && (set_w != 8'h00));
    diode_clear_c:  cover property (en_fall_w[6] && status_ff.diode1_fault_flag);

endmodule : fvs_status

`default_nettype wire

// File: verif/tb_fvs_status.sv
// Testbench: random and corner-case checks of the fault status and voltage id registers
`timescale 1ns/1ps
`default_nettype none

module tb_fvs_status;
    logic             core_clk_i = 1'b0;
    logic             rst_b_i    = 1'b0;
    logic             psel_i     = 1'b0;
    logic             penable_i  = 1'b0;
    logic             pwrite_i   = 1'b0;
    logic [11:0]      paddr_i    = 12'h000;
    logic [31:0]      pwdata_i   = 32'h0;
    logic [31:0]      prdata_o;
    logic [31:0]      rd;
    logic             pready_o;
    logic             pslverr_o;
    logic             err;
    logic [7:0]       v12_r      = 8'h80;
    logic             v12_up     = 1'b0;
    logic [3:0][15:0] tach       = '0;
    logic [3:0][15:0] tmin       = '1;
    logic [3:0]       fan_up     = 4'h0;
    logic [1:0]       dfault     = 2'h0;
    logic [1:0]       dup        = 2'h0;
    logic [1:0][7:0]  dtemp      = '0;
    logic [1:0][7:0]  dread;
    logic [1:0]       dclr;
    logic [4:0]       vid        = 5'h00;
    logic             summ;
    logic             irq;
    int               err_count  = 0;
    int               check_count = 0;
    localparam logic [7:0] LO = 8'h40;
    localparam logic [7:0] HI = 8'hC0;

    // 40 MHz clock
    always #12.5 core_clk_i = ~core_clk_i;

    fvs_status u_fvs_status (
        .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(4'hF),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .volt12_reading_i(v12_r), .volt12_low_limit_i(LO), .volt12_high_limit_i(HI),
        .volt12_update_i(v12_up), .fan_tach_reading_i(tach), .fan_tach_min_i(tmin),
        .fan_update_i(fan_up), .diode_fault_i(dfault), .diode_temp_i(dtemp),
        .diode_update_i(dup), .diode_temp_reading_o(dread), .diode_limit_clear_o(dclr),
        .volt_id_pins_i(vid), .second_status_summary_o(summ), .irq_o(irq)
    );

    // ========================================================================
    // Shared tasks
    // ========================================================================
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // APB transfer: setup, then access until ready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        // Sampled before the design's flops move, so this is the value at the edge
        do @(posedge core_clk_i); while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    // One-cycle update pulses, then settle past the two-cycle irq lag
    task automatic pulse(input logic v, input logic [3:0] f, input logic [1:0] dd);
        @(posedge core_clk_i);
        v12_up <= v;
        fan_up <= f;
        dup <= dd;
        @(posedge core_clk_i);
        v12_up <= 1'b0;
        fan_up <= 4'h0;
        dup <= 2'h0;
        repeat (3) @(posedge core_clk_i);
        @(negedge core_clk_i);
    endtask

    // Write a register and collect any limit-clear pulse in the next cycles
    task automatic wr_clr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] exp);
        logic [1:0] seen;
        seen = 2'h0;
        apb(1'b1, a, d);
        repeat (4) begin
            @(negedge core_clk_i);
            seen |= dclr;
        end
        chk(seen, exp);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    function automatic logic v12_bad(input logic [7:0] r);
        return (r <= LO) || (r > HI);
    endfunction

    // Watchdog: the tests need well under 3000 cycles
    initial begin
        #(25 * 8000);
        err_count++;
        finish_test();
    end

    // ========================================================================
    // Main sequence
    // ========================================================================
    initial begin
        logic [5:0]       cur;
        logic [5:0]       prev;
        logic [7:0]       t8;
        logic [3:0][15:0] tr;
        logic [3:0][15:0] tm;
        logic [11:0]      ra [4];
        ra = '{fvs_pkg::ADDR_FAULT_STATUS, fvs_pkg::ADDR_ENABLE, fvs_pkg::ADDR_START,
               fvs_pkg::ADDR_IRQ_MASK};
        void'($urandom(32'h0d6a));
        repeat (16) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        foreach (ra[i]) begin
            apb(1'b0, ra[i], 32'h0);
            chk(rd, 32'h0);
        end
        apb(1'b1, fvs_pkg::ADDR_FAULT_STATUS, 32'hFFFFFFFF);
        apb(1'b0, fvs_pkg::ADDR_FAULT_STATUS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h200, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        $display("test reset_and_map done");
        // Id pins: random levels, a write in between must not disturb them
        for (int k = 0; k < 4; k++) begin
            vid <= 5'($urandom);
            apb(1'b1, fvs_pkg::ADDR_VOLT_ID, 32'hFFFFFFFF);
            apb(1'b0, fvs_pkg::ADDR_VOLT_ID, 32'h0);
            chk(rd, {27'h0, vid});
        end
        $display("test volt_id done");
        apb(1'b1, fvs_pkg::ADDR_ENABLE, 32'hFD);
        apb(1'b1, fvs_pkg::ADDR_START, 32'h1);
        // Random 12V and fan readings with boundary values first; read after each update
        prev = 6'h00;
        for (int k = 0; k < 20; k++) begin
            t8 = (k == 0) ? LO : (k == 1) ? HI : (k == 2) ? HI + 8'h01 : 8'($urandom);
            for (int f = 0; f < 4; f++) begin
                tm[f] = 16'($urandom_range(16'h01FF, 16'h0100));
                tr[f] = (k < 2) ? tm[f] + 16'(k) : 16'($urandom_range(16'h0200, 16'h0100));
                cur[f + 2] = tr[f] > tm[f];
            end
            cur[1:0] = {1'b0, v12_bad(t8)};
            v12_r <= t8;
            tach <= tr;
            tmin <= tm;
            dtemp <= {~t8, t8};
            pulse(1'b1, 4'hF, 2'h3);
            chk(summ, |(cur | prev));
            chk(irq, 1'b0);
            chk(dread, {~t8, t8});
            apb(1'b0, fvs_pkg::ADDR_FAULT_STATUS, 32'h0);
            chk(rd, {26'h0, cur | prev});
            prev = cur;
        end
        v12_r <= 8'h80;
        tach <= '0;
        pulse(1'b1, 4'hF, 2'h0);
        apb(1'b0, fvs_pkg::ADDR_FAULT_STATUS, 32'h0);
        apb(1'b0, fvs_pkg::ADDR_FAULT_STATUS, 32'h0);
        chk(rd, 32'h0);
        $display("test random_limits done");
        // Both diodes faulted: bits stay through reads until their enables drop
        dfault <= 2'h3;
        pulse(1'b0, 4'h0, 2'h3);
        chk(dread, 16'h8080);
        apb(1'b0, fvs_pkg::ADDR_FAULT_STATUS, 32'h0);
        chk(rd, 32'hC0);
        apb(1'b0, fvs_pkg::ADDR_FAULT_STATUS, 32'h0);
        chk(rd, 32'hC0);
        wr_clr(fvs_pkg::ADDR_ENABLE, 32'h3D, 2'h3);
        apb(1'b0, fvs_pkg::ADDR_FAULT_STATUS, 32'h0);
        chk(rd, 32'h0);
        dfault <= 2'h0;
        wr_clr(fvs_pkg::ADDR_ENABLE, 32'hFD, 2'h0);
        $display("test diode_fault done");
        // Start and enable interplay on the 12V bit
        apb(1'b1, fvs_pkg::ADDR_START, 32'h0);
        v12_r <= 8'h20;
        pulse(1'b1, 4'h0, 2'h0);
        apb(1'b0, fvs_pkg::ADDR_FAULT_STATUS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, fvs_pkg::ADDR_START, 32'h1);
        pulse(1'b1, 4'h0, 2'h0);
        apb(1'b0, fvs_pkg::ADDR_FAULT_STATUS, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, fvs_pkg::ADDR_START, 32'h0);
        apb(1'b1, fvs_pkg::ADDR_ENABLE, 32'hFC);
        pulse(1'b1, 4'h0, 2'h0);
        apb(1'b0, fvs_pkg::ADDR_FAULT_STATUS, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, fvs_pkg::ADDR_START, 32'h1);
        pulse(1'b1, 4'h0, 2'h0);
        apb(1'b0, fvs_pkg::ADDR_FAULT_STATUS, 32'h0);
        chk(rd, 32'h0);
        $display("test start_enable done");
        // Interrupt: raise, mask, unmask, clear
        apb(1'b1, fvs_pkg::ADDR_ENABLE, 32'hFD);
        apb(1'b1, fvs_pkg::ADDR_IRQ_STATUS, 32'hFF);
        apb(1'b1, fvs_pkg::ADDR_IRQ_MASK, 32'h1);
        pulse(1'b1, 4'h0, 2'h0);
        chk(irq, 1'b1);
        apb(1'b0, fvs_pkg::ADDR_IRQ_STATUS, 32'h0);
        chk(rd, 32'h1);
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, (k == 2) ? fvs_pkg::ADDR_IRQ_STATUS : fvs_pkg::ADDR_IRQ_MASK, 32'(k != 0));
            repeat (3) @(negedge core_clk_i);
            chk(irq, k == 1);
        end
        $display("test interrupt done");
        finish_test();
    end
endmodule // tb_fvs_status

`default_nettype wire
